// *** inc/qsw_defs.vh ***
// register offsets, field positions, reset values and bus addresses of the quad switch register bank
`ifndef QSW_DEFS_VH
`define QSW_DEFS_VH
`define QSW_CFG_FIRST 8'h01
`define QSW_CFG_LAST 8'h04
`define QSW_CTRL_ADDR 8'h05
`define QSW_PRESET_FIRST 8'h06
`define QSW_PRESET_LAST 8'h11
`define QSW_BCAST_ADDR 7'h77
`define QSW_CFG_RESET 8'h0A
`define QSW_CTRL_RESET 8'h00
`define QSW_PRESET_RESET 4'h0
`define QSW_AINC_BIT 7
`define QSW_PTR_MSB 6
`define QSW_DELAY_MSB 6
`define QSW_DELAY_LSB 5
`define QSW_RAMP_MSB 4
`define QSW_RAMP_LSB 2
`define QSW_BLEED_MSB 1
`define QSW_BLEED_LSB 0
`define QSW_SRC_MSB 7
`define QSW_SRC_LSB 4
`define QSW_ON_MSB 3
`define QSW_ON_LSB 0
`define QSW_DEV_ADDR 7'h70
`endif

// *** rtl/qsw_bus_cond.v ***
// start, stop and clock-edge detection on synchronised serial bus lines
`timescale 1ns/1ps
module qsw_bus_cond (
  input wire clock,
  input wire rst,
  input wire sclSync,
  input wire sdaSync,
  output wire sclRise,
  output wire sclFall,
  output wire startSeen,
  output wire stopSeen
);
  reg sclLast;
  reg sdaLast;
  always @(posedge clock) begin
    if (rst) begin
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else begin
      sclLast <= sclSync;
      sdaLast <= sdaSync;
    end
  end
  assign sclRise = sclSync & ~sclLast;
  assign sclFall = ~sclSync & sclLast;
  assign startSeen = sclSync & sclLast & sdaLast & ~sdaSync;
  assign stopSeen = sclSync & sclLast & ~sdaLast & sdaSync;
endmodule

// *** rtl/qsw_regbank.v ***
// serial-bus target and register bank of a four-channel power switch
// How it works
// - auto-increment write: 20 clocks plus 9 per register, pointer steps after each byte
// - one register read with dummy write lasts 39 bus clocks
// - auto-increment read: 30 clocks plus 9 per register, pointer steps per byte
// - device also answers the shared broadcast address; command lasts 20 clocks
// - control bits 7..4 pick pin control at 0, bus control at 1
// - control bits 3..0 switch channels under bus control; one write suffices
// - after bias power-up channels follow pins and control reads zero
// - one configuration register per channel at 01h..04h
// - configuration: bit 7 unused, then delay, ramp and bleed fields
// - twelve preset registers at 06h..11h
// - preset bits 3..0 hold channel states, reset zero; upper bits ignored
// - broadcast copies preset bits 3..0 into control bits 3..0
// - broadcast is start, address EEh, preset address byte, stop
// - delay field codes 00..11, reset 00
// - ramp field codes 000..100 valid, reset 010; codes 101..111 are accepted and stored as written
// - bleed field codes 00..11, reset 10
`timescale 1ns/1ps
`include "qsw_defs.vh"
module qsw_regbank #(
  parameter [6:0] DEV_ADDR = `QSW_DEV_ADDR
) (
  input wire clock,
  input wire rst,
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  input wire [3:0] channelOnPin,
  output reg [3:0] channelDrive,
  output reg [7:0] channelSourceAndOn,
  output wire [7:0] channel1Config,
  output wire [7:0] channel2Config,
  output wire [7:0] channel3Config,
  output wire [7:0] channel4Config
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ADDR_ACK = 3'd2;
  localparam ST_RX = 3'd3;
  localparam ST_RX_ACK = 3'd4;
  localparam ST_TX = 3'd5;
  localparam ST_TX_ACK = 3'd6;

  wire sclSync;
  wire sdaSync;
  wire [3:0] onPinSync;
  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;

  qsw_sync #(.WIDTH(2), .INIT(2'h3)) busSync (
    .clock(clock),
    .rst(rst),
    .asyncIn({sclIn, sdaIn}),
    .syncOut({sclSync, sdaSync})
  );
  qsw_sync #(.WIDTH(4), .INIT(4'h0)) pinSync (
    .clock(clock),
    .rst(rst),
    .asyncIn(channelOnPin),
    .syncOut(onPinSync)
  );
  qsw_bus_cond cond (
    .clock(clock),
    .rst(rst),
    .sclSync(sclSync),
    .sdaSync(sdaSync),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  reg [6:0] cfgReg [0:3];
  reg [3:0] presetReg [0:11];
  reg [2:0] state;
  reg [7:0] shifter;
  reg [3:0] bitCount;
  reg [6:0] pointer;
  reg autoInc;
  reg firstByte;
  reg isBroadcast;
  reg bcastPending;
  reg [6:0] bcastPreset;
  reg driveLow;
  reg ackPending;
  integer i;
  localparam [7:0] CFG_RST = `QSW_CFG_RESET;

  function isCfg;
    input [6:0] a;
    begin
      isCfg = ({1'b0, a} >= `QSW_CFG_FIRST) && ({1'b0, a} <= `QSW_CFG_LAST);
    end
  endfunction

  function isPreset;
    input [6:0] a;
    begin
      isPreset = ({1'b0, a} >= `QSW_PRESET_FIRST) && ({1'b0, a} <= `QSW_PRESET_LAST);
    end
  endfunction

  function [7:0] readReg;
    input [6:0] a;
    reg [7:0] c;
    reg [7:0] p;
    begin
      c = {1'b0, a} - `QSW_CFG_FIRST;
      p = {1'b0, a} - `QSW_PRESET_FIRST;
      if (isCfg(a)) begin
        readReg = {1'b0, cfgReg[c[1:0]]};
      end else if ({1'b0, a} == `QSW_CTRL_ADDR) begin
        readReg = channelSourceAndOn;
      end else if (isPreset(a)) begin
        readReg = {4'h0, presetReg[p[3:0]]};
      end else begin
        readReg = 8'h00;
      end
    end
  endfunction

  assign channel1Config = {1'b0, cfgReg[0]};
  assign channel2Config = {1'b0, cfgReg[1]};
  assign channel3Config = {1'b0, cfgReg[2]};
  assign channel4Config = {1'b0, cfgReg[3]};
  assign sdaOut = 1'b0;
  assign sdaOe = driveLow;

  wire [7:0] rxByte = {shifter[6:0], sdaSync};
  wire [7:0] cfgIdx = {1'b0, pointer} - `QSW_CFG_FIRST;
  wire [7:0] preIdx = {1'b0, pointer} - `QSW_PRESET_FIRST;
  wire [7:0] bcIdx = {1'b0, bcastPreset} - `QSW_PRESET_FIRST;
  wire [7:0] ptrData = readReg(pointer);

  // pointer step after each data byte, only when auto-increment is on
  wire [6:0] nextPointer = autoInc ? pointer + 7'h01 : pointer;

  always @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      shifter <= 8'h00;
      bitCount <= 4'h0;
      pointer <= 7'h00;
      autoInc <= 1'b0;
      firstByte <= 1'b0;
      isBroadcast <= 1'b0;
      bcastPending <= 1'b0;
      bcastPreset <= 7'h00;
      driveLow <= 1'b0;
      ackPending <= 1'b0;
      channelSourceAndOn <= `QSW_CTRL_RESET;
      for (i = 0; i < 4; i = i + 1) begin
        cfgReg[i] <= CFG_RST[6:0];
      end
      for (i = 0; i < 12; i = i + 1) begin
        presetReg[i] <= `QSW_PRESET_RESET;
      end
    end else if (startSeen) begin
      state <= ST_ADDR;
      bitCount <= 4'h0;
      driveLow <= 1'b0;
      bcastPending <= 1'b0;
    end else if (stopSeen) begin
      // broadcast acts on its stop so all devices switch together
      if (bcastPending && isPreset(bcastPreset)) begin
        channelSourceAndOn[`QSW_ON_MSB:`QSW_ON_LSB] <= presetReg[bcIdx[3:0]];
      end
      bcastPending <= 1'b0;
      state <= ST_IDLE;
      driveLow <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          driveLow <= 1'b0;
        end
        ST_ADDR: begin
          if (sclRise) begin
            shifter <= rxByte;
            bitCount <= bitCount + 4'h1;
          end else if (sclFall && bitCount == 4'h8) begin
            if (shifter[7:1] == DEV_ADDR) begin
              isBroadcast <= 1'b0;
              driveLow <= 1'b1;
              state <= ST_ADDR_ACK;
            end else if (shifter[7:1] == `QSW_BCAST_ADDR && !shifter[0]) begin
              isBroadcast <= 1'b1;
              driveLow <= 1'b1;
              state <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            bitCount <= 4'h0;
            if (shifter[0] && !isBroadcast) begin
              shifter <= ptrData;
              driveLow <= ~ptrData[7];
              state <= ST_TX;
            end else begin
              driveLow <= 1'b0;
              firstByte <= 1'b1;
              state <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (sclRise) begin
            shifter <= rxByte;
            bitCount <= bitCount + 4'h1;
          end else if (sclFall && bitCount == 4'h8) begin
            driveLow <= 1'b1;
            state <= ST_RX_ACK;
            if (isBroadcast) begin
              bcastPreset <= shifter[6:0];
              bcastPending <= firstByte;
            end else if (firstByte) begin
              autoInc <= shifter[`QSW_AINC_BIT];
              pointer <= shifter[`QSW_PTR_MSB:0];
            end else begin
              if (isCfg(pointer)) begin
                cfgReg[cfgIdx[1:0]] <= shifter[6:0];
              end else if ({1'b0, pointer} == `QSW_CTRL_ADDR) begin
                channelSourceAndOn <= shifter;
              end else if (isPreset(pointer)) begin
                presetReg[preIdx[3:0]] <= shifter[3:0];
              end
              pointer <= nextPointer;
            end
          end
        end
        ST_RX_ACK: begin
          if (sclFall) begin
            driveLow <= 1'b0;
            firstByte <= 1'b0;
            bitCount <= 4'h0;
            state <= ST_RX;
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCount == 4'h7) begin
              driveLow <= 1'b0;
              pointer <= nextPointer;
              state <= ST_TX_ACK;
            end else begin
              driveLow <= ~shifter[6];
              shifter <= {shifter[6:0], 1'b0};
              bitCount <= bitCount + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (sclRise) begin
            ackPending <= ~sdaSync;
          end else if (sclFall) begin
            bitCount <= 4'h0;
            if (ackPending) begin
              shifter <= ptrData;
              driveLow <= ~ptrData[7];
              state <= ST_TX;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // each channel follows its pin or its bus bit
  always @(posedge clock) begin
    if (rst) begin
      channelDrive <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        channelDrive[i] <= channelSourceAndOn[`QSW_SRC_LSB + i] ?
          channelSourceAndOn[`QSW_ON_LSB + i] : onPinSync[i];
      end
    end
  end
endmodule

// *** rtl/qsw_sync.v ***
// two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ps
module qsw_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;
  always @(posedge clock) begin
    if (rst) begin
      stage1 <= INIT;
      syncOut <= INIT;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

// *** verification/qsw_bus_master.sv ***
// behavioural serial bus controller; clock rests high between frames
`timescale 1ns/1ps
module qsw_bus_master (
  input wire clock,
  input wire sda,
  output reg scl,
  output reg sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task tick(input integer n);
    repeat (n) @(negedge clock);
  endtask
  // start or repeated start, clock left low
  task startCond;
    begin
      sdaLow = 1'b0;
      tick(5);
      scl = 1'b1;
      tick(3);
      sdaLow = 1'b1;
      tick(3);
      scl = 1'b0;
    end
  endtask
  // every transfer is closed this way
  task stopCond;
    begin
      tick(2);
      sdaLow = 1'b1;
      tick(3);
      scl = 1'b1;
      tick(3);
      sdaLow = 1'b0;
      tick(6);
    end
  endtask
  // one bit of 400 ns: low for 5 cycles, high for 3
  task bitIo(input b, output v);
    begin
      tick(2);
      sdaLow = ~b;
      tick(3);
      scl = 1'b1;
      tick(1);
      v = sda;
      tick(2);
      scl = 1'b0;
    end
  endtask
  // nine clocks per byte including the acknowledge
  task xfer(input [7:0] d, input ackBit, output [7:0] v, output ackSeen);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bitIo(d[i], v[i]);
      bitIo(ackBit, ackSeen);
    end
  endtask
endmodule

// *** verification/qsw_regbank_properties.sv ***
// assertion checker for the quad switch register bank ports
`timescale 1ns/1ps
module qsw_regbank_properties (
  input wire clock,
  input wire rst,
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire [3:0] channelOnPin,
  input wire [3:0] channelDrive,
  input wire [7:0] channelSourceAndOn,
  input wire [7:0] channel1Config,
  input wire [7:0] channel2Config,
  input wire [7:0] channel3Config,
  input wire [7:0] channel4Config
);
  reg [3:0] idle;
  reg sclQ;
  reg sdaQ;
  wire [7:0] ctl = channelSourceAndOn;
  wire [31:0] cfgAll = {channel1Config, channel2Config, channel3Config, channel4Config};
  // cycles since the last bus line edge
  always @(posedge clock) begin
    sclQ <= sclIn;
    sdaQ <= sdaIn;
    if (rst || sclIn != sclQ || sdaIn != sdaQ) begin
      idle <= 4'h0;
    end else if (idle != 4'hF) begin
      idle <= idle + 4'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_DRIVE_MIX: assert property (($stable(ctl) && $stable(channelOnPin))[*5] |->
    channelDrive == ((ctl[7:4] & ctl[3:0]) | (~ctl[7:4] & channelOnPin))) else $error("drive mix wrong");
  AST_DRIVE_NEXT: assert property (!$stable(ctl) && ctl[7:4] == 4'hF |=> channelDrive == ctl[3:0])
    else $error("drive late");
  AST_RESET: assert property (disable iff (1'b0) rst |=> ctl == 8'h00 && channelDrive == 4'h0 &&
    cfgAll == 32'h0A0A0A0A && !sdaOe) else $error("reset values wrong");
  AST_CFG_BIT7: assert property ({channel1Config[7], channel2Config[7], channel3Config[7], channel4Config[7]}
    == 4'h0) else $error("config bit 7 set");
  AST_CTRL_QUIET: assert property (idle > 4'h8 |-> $stable(ctl)) else $error("control moved idle");
  AST_CFG_QUIET: assert property (idle > 4'h8 |-> $stable(cfgAll)) else $error("config moved idle");
  AST_OE_SCL_LOW: assert property (!$stable(sdaOe) |-> !sclIn) else $error("data moved with clock high");
  AST_OPEN_DRAIN: assert property (sdaOut == 1'b0) else $error("data driven high");
endmodule
bind qsw_regbank qsw_regbank_properties CHK (.clock(clock), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .channelOnPin(channelOnPin), .channelDrive(channelDrive),
  .channelSourceAndOn(channelSourceAndOn), .channel1Config(channel1Config),
  .channel2Config(channel2Config), .channel3Config(channel3Config), .channel4Config(channel4Config));

// *** verification/quad_switch_i2c_regbank_tb.sv ***
// self-checking bench for the quad switch register bank
`timescale 1ns/1ps
`include "qsw_defs.vh"
module quad_switch_i2c_regbank_tb;
  localparam [7:0] DEV_W = {`QSW_DEV_ADDR, 1'b0};
  // rows of register, written byte, expected read
  localparam [191:0] ROWS = {24'h01FF7F, 24'h021515, 24'h036E6E, 24'h045353,
    24'h060A0A, 24'h110505, 24'h127700, 24'h003C00};
  reg clock;
  reg rst;
  reg [3:0] channelOnPin;
  wire scl, sdaLow, sdaOut, sdaOe, sda;
  wire [3:0] channelDrive;
  wire [7:0] ctl, cfg1, cfg2, cfg3, cfg4;
  integer failCount;
  integer testsRun;
  integer j;
  integer sclCount;
  // a transfer that starts from an idle bus shows one rising clock edge less than its clock figure
  always @(posedge scl) sclCount = sclCount + 1;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  reg [7:0] r;
  reg a;
  assign sda = ~(sdaLow | sdaOe);
  qsw_regbank DUT (.clock(clock), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .channelOnPin(channelOnPin), .channelDrive(channelDrive), .channelSourceAndOn(ctl),
    .channel1Config(cfg1), .channel2Config(cfg2), .channel3Config(cfg3), .channel4Config(cfg4));
  qsw_bus_master BM (.clock(clock), .sda(sda), .scl(scl), .sdaLow(sdaLow));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task completeRun;
    begin
      $display("checks %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      testsRun = testsRun + 1;
      if (got !== exp) begin
        failCount = failCount + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task sendAddr(input [7:0] b);
    begin
      BM.startCond;
      BM.xfer(b, 1'b1, r, a);
    end
  endtask
  task wr(input [7:0] sub);
    begin
      sendAddr(DEV_W);
      chk({7'h0, a}, 8'h00);
      BM.xfer(sub, 1'b1, r, a);
      foreach (txq[k]) BM.xfer(txq[k], 1'b1, r, a);
      BM.stopCond;
    end
  endtask
  task rd(input [7:0] sub, input integer n);
    begin
      sendAddr(DEV_W);
      BM.xfer(sub, 1'b1, r, a);
      sendAddr(DEV_W | 8'h01);
      rxq = {};
      repeat (n) begin
        BM.xfer(8'hFF, rxq.size() == n - 1, r, a);
        rxq.push_back(r);
      end
      BM.stopCond;
    end
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    failCount = failCount + 1;
    completeRun;
  end
  initial begin
    rst = 1'b1;
    channelOnPin = 4'hA;
    failCount = 0;
    testsRun = 0;
    sclCount = 0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (6) @(negedge clock);
    chk(ctl, 8'h00);
    chk({4'h0, channelDrive}, 8'h0A);
    chk(cfg4, 8'h0A);
    for (j = 0; j < 8; j = j + 1) begin
      txq = {ROWS[183 - j * 24 -: 8]};
      wr(ROWS[191 - j * 24 -: 8]);
      sclCount = 0;
      rd(ROWS[191 - j * 24 -: 8], 1);
      chk(sclCount[7:0], 8'h26);
      chk(rxq[0], ROWS[175 - j * 24 -: 8]);
    end
    chk(cfg1, 8'h7F);
    txq = {8'h21, 8'h32, 8'h43, 8'h54};
    sclCount = 0;
    wr(8'h81);
    chk(sclCount[7:0], 8'h37);
    chk(cfg4, 8'h54);
    sclCount = 0;
    rd(8'h81, 4);
    chk(sclCount[7:0], 8'h41);
    foreach (rxq[k]) chk(rxq[k], txq[k]);
    txq = {8'h11, 8'h22};
    wr(8'h02);
    chk(cfg2, 8'h22);
    chk(cfg3, 8'h43);
    channelOnPin = 4'h5;
    txq = {8'h30};
    wr(8'h05);
    chk({4'h0, channelDrive}, 8'h04);
    txq = {8'h33};
    wr(8'h05);
    chk({4'h0, channelDrive}, 8'h07);
    txq = {8'hF0};
    wr(8'h05);
    sclCount = 0;
    sendAddr(8'hEE);
    chk({7'h0, a}, 8'h00);
    BM.xfer(8'h06, 1'b1, r, a);
    BM.stopCond;
    chk(sclCount[7:0], 8'h13);
    chk(ctl, 8'hFA);
    chk({4'h0, channelDrive}, 8'h0A);
    sendAddr(8'hEF);
    BM.stopCond;
    chk({7'h0, a}, 8'h01);
    sendAddr(8'hE2);
    BM.stopCond;
    chk({7'h0, a}, 8'h01);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    repeat (6) @(negedge clock);
    chk(ctl, 8'h00);
    chk(cfg3, 8'h0A);
    chk({4'h0, channelDrive}, 8'h05);
    completeRun;
  end
endmodule
